// File: hw/tgs_pkg.sv
package tgs_pkg;

    // register bus shape
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 16;

    // register offsets; table entries live in the profile bank
    localparam logic [7:0] REG_GLOBAL = 8'h00;
    localparam logic [7:0] TBL_FIRST = 8'h01;
    localparam logic [7:0] TBL_LAST = 8'h94;
    localparam logic [7:0] REG_FIRST_PTR = 8'h95;
    localparam logic [7:0] REG_LAST_PTR = 8'h96;
    localparam logic [7:0] REG_START_GAIN = 8'h97;
    localparam logic [7:0] REG_DWELL = 8'h98;
    localparam logic [7:0] REG_MODE = 8'h99;
    localparam logic [7:0] REG_WHOLE = 8'h9a;
    localparam logic [7:0] REG_SLOPE = 8'h9b;

    // field positions
    localparam int unsigned BANK_SEL_BIT = 2;
    localparam int unsigned INTERP_BIT = 7;
    localparam int unsigned SOFT_BIT = 5;
    localparam int unsigned LIN_BIT = 4;
    localparam int unsigned FIXED_BIT = 3;
    localparam int unsigned ENTRY_DIR_BIT = 8;

    // curve memory
    localparam int unsigned TABLE_DEPTH = 148;
    localparam int unsigned ENTRY_W = 9;

    // gain is held in eighth-dB units above the -5 dB floor
    localparam int unsigned GAIN_W = 9;
    localparam logic [5:0] WHOLE_MAX = 6'h24;
    localparam logic [8:0] GAIN_TOP = 9'h127;
    localparam logic [8:0] FINE_STEP = 9'h001;
    localparam logic [8:0] WHOLE_STEP = 9'h008;
    localparam logic [2:0] SUB_LAST = 3'h7;

    // timing: dwell unit and mclk cycles per channel sample period
    localparam int unsigned DWELL_MULT = 33;
    localparam logic [13:0] DWELL_MULT_W = 14'(DWELL_MULT);
    localparam int unsigned SAMPLE_DIV = 2;

    // reset values
    localparam logic [7:0] RST_PTR = 8'h01;
    localparam logic [7:0] RST_ZERO = 8'h00;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WALK = 2'b01,
        ST_DWELL = 2'b10,
        ST_RETURN = 2'b11
    } tgs_state_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] data;
    } tgs_wr_type;

    typedef struct packed {
        logic [5:0] whole;
        logic [2:0] eighth;
    } tgs_gain_type;

endpackage : tgs_pkg

// File: hw/tgs_curve_mem.sv
`timescale 1ns/1ps
`default_nettype none

module tgs_curve_mem #(
    parameter int unsigned DEPTH = tgs_pkg::TABLE_DEPTH,
    parameter int unsigned WIDTH = tgs_pkg::ENTRY_W
) (
    input wire logic mclk, // system clock
    input wire logic wr_en, // write strobe
    input wire logic [7:0] wr_idx, // 1-based entry index
    input wire logic [WIDTH-1:0] wr_data, // entry to store
    input wire logic [7:0] rd_a_idx, // engine read index
    output logic [WIDTH-1:0] rd_a_data, // engine read entry
    input wire logic [7:0] rd_b_idx, // readback index
    output logic [WIDTH-1:0] rd_b_data // readback entry
);

    logic [WIDTH-1:0] mem_r [DEPTH];

    function automatic logic in_range(input logic [7:0] idx);
        in_range = (idx != 8'h00) && (32'(idx) <= DEPTH);
    endfunction : in_range

    // no reset on the array: software must load it before use
    always_ff @(posedge mclk)
    begin
        if (wr_en && in_range(wr_idx))
        begin
            mem_r[wr_idx - 8'h01] <= wr_data;
        end
    end

    // out-of-range pointers read as a zero entry
    assign rd_a_data = in_range(rd_a_idx) ? mem_r[rd_a_idx - 8'h01] : '0;
    assign rd_b_data = in_range(rd_b_idx) ? mem_r[rd_b_idx - 8'h01] : '0;

endmodule : tgs_curve_mem

`default_nettype wire

// File: hw/tgs_sequencer.sv
// Function
// - last pointer picks final entry, 1..148
// - initial gain code is -5 dB plus code
// - final gain from pointers, decrements, fine offset
// - hold final gain 33 times dwell field
// - after dwell, return 1 dB per sample
// - fine mode: eighth dB per N samples
// - coarse mode: 1 dB per 8N samples
// - retrigger bit repeats curve without trigger pin
// - linear select ramps upward at set rate
// - fixed select: whole plus eighth, static gain
// - whole-dB codes above 0x24 act as 0x24
// - eighth-dB field adds 0.125 dB per code
// - gain changes only on sampling instants
// - 148 nine-bit entries at addresses 1..148
// - entry bit 8 direction, bits 7:0 duration
// - fine mode splits 1 dB into eight steps
// - trigger loads initial gain, starts at first
// - stop at last entry or limit, then hold
// - idle after return until new trigger
// - trigger sampled on sample-clock rising edge
// - retrigger mode restarts each cycle until cleared
// - retrigger write acts at the next sample instant
// - bank select chooses profile or general bank
// - first pointer picks first entry, 1..148
// - linear fine mode: N samples per step
`timescale 1ns/1ps
`default_nettype none

module tgs_sequencer #(
    parameter int unsigned DEPTH = tgs_pkg::TABLE_DEPTH
) (
    input wire logic mclk, // input clock, twice the sample rate
    input wire logic sys_rst, // async reset, active high
    input wire logic trig, // trigger pin level
    input wire logic reg_wr_en, // register write strobe
    input wire tgs_pkg::tgs_wr_type reg_wr, // write address and data
    input wire logic reg_rd_en, // register read strobe
    input wire logic [7:0] reg_rd_addr, // read address
    output logic [15:0] reg_rd_data, // read data, registered
    output logic reg_rd_valid, // read data valid pulse
    output tgs_pkg::tgs_gain_type gain, // amplifier gain setting
    output logic samp_en, // channel sample instant pulse
    output logic seq_busy // curve walk, dwell or return active
);

    // register file
    logic bank_sel_r;
    logic [7:0] first_ptr_r;
    logic [7:0] last_ptr_r;
    logic interp_r;
    logic [5:0] start_gain_r;
    logic [7:0] dwell_r;
    logic soft_r;
    logic lin_r;
    logic fixed_r;
    logic [2:0] fine_r;
    logic [5:0] whole_r;
    logic [7:0] slope_r;

    // engine state
    tgs_pkg::tgs_state_type state_r;
    logic samp_ph_r;
    logic trig_q_r;
    logic soft_pend_r;
    logic [8:0] gain_r;
    logic [7:0] idx_r;
    logic [7:0] rem_r;
    logic [2:0] sub_idx_r;
    logic [7:0] sub_cnt_r;
    logic [13:0] dwell_cnt_r;

    logic [8:0] entry;
    logic [8:0] rb_entry;
    logic wr_profile;
    logic trig_rise;
    logic start;
    logic [8:0] start_code;
    logic [7:0] sub_len;
    logic dir_dn;
    logic [8:0] step;
    logic at_limit;
    logic sub_end;
    logic [8:0] ret_gap;
    logic [8:0] ret_step;
    logic [8:0] ret_next;
    logic [7:0] span;

    function automatic logic [5:0] clamp_whole(input logic [5:0] code);
        clamp_whole = (code > tgs_pkg::WHOLE_MAX) ? tgs_pkg::WHOLE_MAX : code;
    endfunction : clamp_whole

    // profile bank addresses: table entries and curve controls
    function automatic logic in_profile(input logic [7:0] addr);
        in_profile = (addr >= tgs_pkg::TBL_FIRST)
            && (addr <= tgs_pkg::REG_SLOPE);
    endfunction : in_profile

    function automatic logic [7:0] at_least_one(input logic [7:0] n);
        at_least_one = (n == 8'h00) ? 8'h01 : n;
    endfunction : at_least_one

    tgs_curve_mem #(
        .DEPTH(DEPTH),
        .WIDTH(tgs_pkg::ENTRY_W)
    ) u_mem (
        .mclk(mclk),
        .wr_en(wr_profile && (reg_wr.addr <= tgs_pkg::TBL_LAST)),
        .wr_idx(reg_wr.addr),
        .wr_data(reg_wr.data[8:0]),
        .rd_a_idx(idx_r),
        .rd_a_data(entry),
        .rd_b_idx(reg_rd_addr),
        .rd_b_data(rb_entry)
    );

    // register writes
    assign wr_profile = reg_wr_en && bank_sel_r && in_profile(reg_wr.addr);

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            bank_sel_r <= 1'b0;
        end
        else if (reg_wr_en && (reg_wr.addr == tgs_pkg::REG_GLOBAL))
        begin
            bank_sel_r <= reg_wr.data[tgs_pkg::BANK_SEL_BIT];
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            first_ptr_r <= tgs_pkg::RST_PTR;
            last_ptr_r <= tgs_pkg::RST_PTR;
            interp_r <= 1'b0;
            start_gain_r <= '0;
            dwell_r <= tgs_pkg::RST_ZERO;
            soft_r <= 1'b0;
            lin_r <= 1'b0;
            fixed_r <= 1'b0;
            fine_r <= '0;
            whole_r <= '0;
            slope_r <= tgs_pkg::RST_ZERO;
        end
        else if (wr_profile)
        begin
            if (reg_wr.addr == tgs_pkg::REG_FIRST_PTR)
            begin
                first_ptr_r <= reg_wr.data[7:0];
            end
            else if (reg_wr.addr == tgs_pkg::REG_LAST_PTR)
            begin
                last_ptr_r <= reg_wr.data[7:0];
            end
            else if (reg_wr.addr == tgs_pkg::REG_START_GAIN)
            begin
                interp_r <= reg_wr.data[tgs_pkg::INTERP_BIT];
                start_gain_r <= reg_wr.data[5:0];
            end
            else if (reg_wr.addr == tgs_pkg::REG_DWELL)
            begin
                dwell_r <= reg_wr.data[7:0];
            end
            else if (reg_wr.addr == tgs_pkg::REG_MODE)
            begin
                soft_r <= reg_wr.data[tgs_pkg::SOFT_BIT];
                lin_r <= reg_wr.data[tgs_pkg::LIN_BIT];
                fixed_r <= reg_wr.data[tgs_pkg::FIXED_BIT];
                fine_r <= reg_wr.data[2:0];
            end
            else if (reg_wr.addr == tgs_pkg::REG_WHOLE)
            begin
                whole_r <= reg_wr.data[5:0];
            end
            else if (reg_wr.addr == tgs_pkg::REG_SLOPE)
            begin
                slope_r <= reg_wr.data[7:0];
            end
        end
    end

    // readback: register 0 in both banks, unmapped reads give zero
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            reg_rd_data <= '0;
            reg_rd_valid <= 1'b0;
        end
        else
        begin
            reg_rd_valid <= reg_rd_en;
            if (reg_rd_en)
            begin
                reg_rd_data <= '0;
                if (reg_rd_addr == tgs_pkg::REG_GLOBAL)
                begin
                    reg_rd_data[tgs_pkg::BANK_SEL_BIT] <= bank_sel_r;
                end
                else if (!bank_sel_r || !in_profile(reg_rd_addr))
                begin
                    reg_rd_data <= '0;
                end
                else if (reg_rd_addr <= tgs_pkg::TBL_LAST)
                begin
                    reg_rd_data[8:0] <= rb_entry;
                end
                else if (reg_rd_addr == tgs_pkg::REG_FIRST_PTR)
                begin
                    reg_rd_data[7:0] <= first_ptr_r;
                end
                else if (reg_rd_addr == tgs_pkg::REG_LAST_PTR)
                begin
                    reg_rd_data[7:0] <= last_ptr_r;
                end
                else if (reg_rd_addr == tgs_pkg::REG_START_GAIN)
                begin
                    reg_rd_data[7:0] <= {interp_r, 1'b0, start_gain_r};
                end
                else if (reg_rd_addr == tgs_pkg::REG_DWELL)
                begin
                    reg_rd_data[7:0] <= dwell_r;
                end
                else if (reg_rd_addr == tgs_pkg::REG_MODE)
                begin
                    reg_rd_data[5:0] <= {soft_r, lin_r, fixed_r, fine_r};
                end
                else if (reg_rd_addr == tgs_pkg::REG_WHOLE)
                begin
                    reg_rd_data[5:0] <= whole_r;
                end
                else
                begin
                    reg_rd_data[7:0] <= slope_r;
                end
            end
        end
    end

    // channel sample period is two mclk cycles
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            samp_ph_r <= 1'b0;
        end
        else
        begin
            samp_ph_r <= ~samp_ph_r;
        end
    end

    assign samp_en = samp_ph_r;

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            trig_q_r <= 1'b0;
        end
        else if (samp_en)
        begin
            trig_q_r <= trig;
        end
    end

    assign trig_rise = samp_en && trig && !trig_q_r;

    // a retrigger write is remembered until the next sample instant;
    // a fresh write in the consuming cycle keeps it pending
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            soft_pend_r <= 1'b0;
        end
        else if (wr_profile && (reg_wr.addr == tgs_pkg::REG_MODE)
                 && reg_wr.data[tgs_pkg::SOFT_BIT])
        begin
            soft_pend_r <= 1'b1;
        end
        else if (samp_en)
        begin
            soft_pend_r <= 1'b0;
        end
    end

    assign start_code = {clamp_whole(start_gain_r), 3'b000};
    assign span = (last_ptr_r > first_ptr_r) ? last_ptr_r - first_ptr_r
        : 8'h00;
    assign ret_gap = (gain_r > start_code) ? gain_r - start_code
        : start_code - gain_r;
    assign ret_step = (ret_gap > tgs_pkg::WHOLE_STEP) ? tgs_pkg::WHOLE_STEP
        : ret_gap;
    assign ret_next = (gain_r > start_code) ? gain_r - ret_step
        : gain_r + ret_step;

    // a trigger restarts the curve from any state
    assign start = samp_en && !fixed_r && (trig_rise || soft_pend_r
        || (state_r == tgs_pkg::ST_RETURN && ret_gap == 9'h000
            && soft_r));

    // each entry is eight sub-periods; linear mode takes its rate
    assign sub_len = lin_r ? at_least_one(slope_r)
        : at_least_one(entry[7:0]);
    assign dir_dn = !lin_r && entry[tgs_pkg::ENTRY_DIR_BIT];
    assign sub_end = (sub_cnt_r == sub_len);

    // the eighth sub-step closes the 1 dB; coarse mode jumps at once
    always_comb
    begin
        if (sub_idx_r != tgs_pkg::SUB_LAST)
        begin
            step = interp_r ? tgs_pkg::FINE_STEP : 9'h000;
        end
        else
        begin
            step = interp_r ? tgs_pkg::FINE_STEP : tgs_pkg::WHOLE_STEP;
        end
    end

    assign at_limit = dir_dn ? (gain_r < step)
        : (gain_r > tgs_pkg::GAIN_TOP - step);

    // sequencer: walk, dwell, return, idle; all moves on sample instants
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_r <= tgs_pkg::ST_IDLE;
            gain_r <= '0;
            idx_r <= tgs_pkg::RST_PTR;
            rem_r <= '0;
            sub_idx_r <= '0;
            sub_cnt_r <= 8'h01;
            dwell_cnt_r <= '0;
        end
        else if (samp_en)
        begin
            if (fixed_r)
            begin
                state_r <= tgs_pkg::ST_IDLE;
                gain_r <= {clamp_whole(whole_r), fine_r};
            end
            else if (start)
            begin
                state_r <= tgs_pkg::ST_WALK;
                gain_r <= start_code;
                idx_r <= first_ptr_r;
                rem_r <= span;
                sub_idx_r <= '0;
                sub_cnt_r <= 8'h01;
            end
            else
            begin
                case (state_r)
                    tgs_pkg::ST_WALK:
                    begin
                        if (!sub_end)
                        begin
                            sub_cnt_r <= sub_cnt_r + 8'h01;
                        end
                        else if ((sub_idx_r == tgs_pkg::SUB_LAST
                                  && rem_r == 8'h00)
                                 || (step != 9'h000 && at_limit))
                        begin
                            // final gain reached; hold it, or start the return at once when dwell is zero
                            dwell_cnt_r <= 14'(dwell_r)
                                * tgs_pkg::DWELL_MULT_W;
                            state_r <= (dwell_r == 8'h00)
                                ? tgs_pkg::ST_RETURN : tgs_pkg::ST_DWELL;
                            gain_r <= (dwell_r == 8'h00) ? ret_next : gain_r;
                        end
                        else
                        begin
                            sub_cnt_r <= 8'h01;
                            sub_idx_r <= sub_idx_r + 3'h1;
                            gain_r <= dir_dn ? gain_r - step : gain_r + step;
                            if (sub_idx_r == tgs_pkg::SUB_LAST)
                            begin
                                rem_r <= rem_r - 8'h01;
                                idx_r <= idx_r + 8'h01;
                            end
                        end
                    end
                    tgs_pkg::ST_DWELL:
                    begin
                        if (dwell_cnt_r <= 14'h0001)
                        begin
                            state_r <= tgs_pkg::ST_RETURN;
                            gain_r <= ret_next;
                        end
                        else
                        begin
                            dwell_cnt_r <= dwell_cnt_r - 14'h0001;
                        end
                    end
                    tgs_pkg::ST_RETURN:
                    begin
                        if (ret_gap == 9'h000)
                        begin
                            state_r <= tgs_pkg::ST_IDLE;
                        end
                        else
                        begin
                            gain_r <= ret_next;
                        end
                    end
                    default:
                    begin
                        state_r <= tgs_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    assign gain = tgs_pkg::tgs_gain_type'(gain_r);
    assign seq_busy = (state_r != tgs_pkg::ST_IDLE);

endmodule : tgs_sequencer

`default_nettype wire

// File: bench/tgs_sequencer_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module tgs_sequencer_monitor (
    input wire logic mclk, // clock
    input wire logic sys_rst, // reset
    input wire logic trig, // trigger pin
    input wire logic reg_wr_en, // write strobe
    input wire tgs_pkg::tgs_wr_type reg_wr, // write word
    input wire logic reg_rd_en, // read strobe
    input wire logic [7:0] reg_rd_addr, // read address
    input wire logic [15:0] reg_rd_data, // read data
    input wire logic reg_rd_valid, // read valid
    input wire tgs_pkg::tgs_gain_type gain, // gain
    input wire logic samp_en, // sample instant
    input wire logic seq_busy // curve active
);
    logic bank_r;
    logic fixed_r;
    logic soft_r;
    logic trig_prev_r;
    logic [5:0] start_r;

    // mode shadow rebuilt from write traffic, so no internal probing
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            bank_r <= 1'b0;
            fixed_r <= 1'b0;
            soft_r <= 1'b0;
            start_r <= 6'h00;
        end
        else if (reg_wr_en)
        begin
            if (reg_wr.addr == 8'h00)
                bank_r <= reg_wr.data[2];
            if (bank_r && reg_wr.addr == 8'h99)
            begin
                fixed_r <= reg_wr.data[3];
                soft_r <= reg_wr.data[5];
            end
            if (bank_r && reg_wr.addr == 8'h97)
                start_r <= reg_wr.data[5:0];
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            trig_prev_r <= 1'b0;
        else if (samp_en)
            trig_prev_r <= trig;
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    property p_samp_alt;
        !$past(sys_rst) |-> samp_en != $past(samp_en);
    endproperty
    a_samp_alt: assert property (p_samp_alt)
        else $error("sample pulse not alternating");
    property p_gain_sync;
        $changed(gain) |-> $past(samp_en);
    endproperty
    a_gain_sync: assert property (p_gain_sync)
        else $error("gain moved off a sample instant");
    property p_busy_rise;
        $rose(seq_busy) |-> $past(samp_en);
    endproperty
    a_busy_rise: assert property (p_busy_rise)
        else $error("curve started off a sample instant");
    property p_rd_answer;
        reg_rd_en |=> reg_rd_valid;
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read not answered");
    property p_rd_quiet;
        !reg_rd_en |=> !reg_rd_valid && $stable(reg_rd_data);
    endproperty
    a_rd_quiet: assert property (p_rd_quiet)
        else $error("read port moved without a read");
    property p_trig_start;
        samp_en && trig && !trig_prev_r && !fixed_r
            |=> seq_busy && gain == {start_r, 3'h0};
    endproperty
    a_trig_start: assert property (p_trig_start)
        else $error("trigger did not load start gain");
    property p_fixed_idle;
        fixed_r && !seq_busy |=> !seq_busy;
    endproperty
    a_fixed_idle: assert property (p_fixed_idle)
        else $error("sequencer ran in fixed mode");
    property p_stay_idle;
        !seq_busy && !soft_r && !(samp_en && trig) |=> !seq_busy;
    endproperty
    a_stay_idle: assert property (p_stay_idle)
        else $error("curve started without trigger");
    property p_end_at_start;
        $fell(seq_busy) |-> gain == {start_r, 3'h0};
    endproperty
    a_end_at_start: assert property (p_end_at_start)
        else $error("curve ended away from start gain");
    property p_whole_cap;
        gain.whole <= tgs_pkg::WHOLE_MAX;
    endproperty
    a_whole_cap: assert property (p_whole_cap)
        else $error("whole gain above top code");
endmodule : tgs_sequencer_monitor

bind tgs_sequencer tgs_sequencer_monitor tgs_sequencer_monitor_i (
    .mclk(mclk), .sys_rst(sys_rst), .trig(trig), .reg_wr_en(reg_wr_en),
    .reg_wr(reg_wr), .reg_rd_en(reg_rd_en), .reg_rd_addr(reg_rd_addr),
    .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .gain(gain),
    .samp_en(samp_en), .seq_busy(seq_busy)
);

`default_nettype wire

// File: bench/tgs_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module tgs_ctrl (
    input wire logic mclk, // clock
    input wire logic samp_en, // sample instant
    output logic trig, // trigger pin
    output logic reg_wr_en, // write strobe
    output tgs_pkg::tgs_wr_type reg_wr, // write word
    output logic reg_rd_en, // read strobe
    output logic [7:0] reg_rd_addr, // read address
    input wire logic [15:0] reg_rd_data, // read data
    input wire logic reg_rd_valid // read valid
);
    initial
    begin
        trig = 1'b0;
        reg_wr_en = 1'b0;
        reg_wr = '0;
        reg_rd_en = 1'b0;
        reg_rd_addr = 8'h00;
    end

    // idle bus shows the inverse, so stale words are never reused
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_wr_en <= 1'b1;
        reg_wr <= {a, d};
        @(posedge mclk);
        reg_wr_en <= 1'b0;
        reg_wr <= ~{a, d};
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] d,
        output logic v);
        @(posedge mclk);
        reg_rd_en <= 1'b1;
        reg_rd_addr <= a;
        @(posedge mclk);
        reg_rd_en <= 1'b0;
        reg_rd_addr <= ~a;
        #1;
        d = reg_rd_data;
        v = reg_rd_valid;
    endtask : rd

    // high for exactly one sample instant, low at the next one
    task automatic pulse;
        @(posedge mclk iff samp_en == 1'b0);
        trig <= 1'b1;
        @(posedge mclk);
        trig <= 1'b0;
    endtask : pulse
endmodule : tgs_ctrl

`default_nettype wire

// File: bench/test_time_gain_sequencer.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(what, exp, got) \
    begin \
        compares++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("Error %s expected %0h seen %0h", what, exp, got); \
        end \
    end

module test_time_gain_sequencer;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic trig;
    logic reg_wr_en;
    tgs_pkg::tgs_wr_type reg_wr;
    logic reg_rd_en;
    logic [7:0] reg_rd_addr;
    logic [15:0] reg_rd_data;
    logic reg_rd_valid;
    tgs_pkg::tgs_gain_type gain;
    logic samp_en;
    logic seq_busy;
    logic [8:0] g;
    logic [8:0] last_g;
    logic [8:0] tbl [6] = '{9'h00f, 9'h008, 9'h005, 9'h108, 9'h007, 9'h00a};
    int compares = 0;
    int n_mismatch = 0;
    int cnt;

    assign g = gain;
    always #2 mclk = ~mclk;

    tgs_sequencer tgs_sequencer_i (.mclk(mclk), .sys_rst(sys_rst),
        .trig(trig), .reg_wr_en(reg_wr_en), .reg_wr(reg_wr),
        .reg_rd_en(reg_rd_en), .reg_rd_addr(reg_rd_addr),
        .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
        .gain(gain), .samp_en(samp_en), .seq_busy(seq_busy));
    tgs_ctrl tgs_ctrl_i (.mclk(mclk), .samp_en(samp_en), .trig(trig),
        .reg_wr_en(reg_wr_en), .reg_wr(reg_wr), .reg_rd_en(reg_rd_en),
        .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data),
        .reg_rd_valid(reg_rd_valid));

    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict

    task automatic chk_rd(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        logic v;
        tgs_ctrl_i.rd(a, d, v);
        `CHK("read valid", 1'b1, v)
        `CHK("read data", e, d)
    endtask : chk_rd

    task automatic setup(input logic [7:0] first, input logic [7:0] last,
        input logic [7:0] sg, input logic [7:0] hold,
        input logic [7:0] slope, input logic [15:0] mode);
        tgs_ctrl_i.wr(8'h95, {8'h00, first});
        tgs_ctrl_i.wr(8'h96, {8'h00, last});
        tgs_ctrl_i.wr(8'h97, {8'h00, sg});
        tgs_ctrl_i.wr(8'h98, {8'h00, hold});
        tgs_ctrl_i.wr(8'h9b, {8'h00, slope});
        tgs_ctrl_i.wr(8'h99, mode);
    endtask : setup

    // st, step, peak in eighth-dB units; times in mclk cycles
    task automatic run(input logic [8:0] st, input int dly,
        input logic [8:0] step, input logic [8:0] peak, input int hold);
        int n;
        int pk;
        logic [8:0] g0;
        logic [8:0] after;
        tgs_ctrl_i.pulse();
        #1;
        g0 = g;
        `CHK("start gain", st, g0)
        n = 0;
        while (g === g0 && n < 4000)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        `CHK("first step time", dly, n)
        `CHK("first step size", step, g - g0)
        pk = (g === peak) ? 1 : 0;
        after = st;
        while (seq_busy === 1'b1 && n < 4000)
        begin
            @(posedge mclk);
            #1;
            n++;
            if (g === peak)
                pk++;
            else if (pk != 0 && after === st)
                after = g;
        end
        `CHK("peak time", hold, pk)
        `CHK("return step", (peak - st > 9'd8) ? peak - 9'd8 : st, after)
        `CHK("end gain", st, g)
        repeat (40) @(posedge mclk);
        #1;
        `CHK("idle", 1'b0, seq_busy)
    endtask : run

    initial
    begin
        #100000;
        n_mismatch++;
        give_verdict();
    end

    initial
    begin
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        tgs_ctrl_i.wr(8'h98, 16'h0005);
        tgs_ctrl_i.wr(8'h00, 16'h0004);
        chk_rd(8'h00, 16'h0004);
        chk_rd(8'h98, 16'h0000);
        chk_rd(8'h95, 16'h0001);
        chk_rd(8'h96, 16'h0001);
        tgs_ctrl_i.wr(8'h01, 16'h01ff);
        tgs_ctrl_i.wr(8'h94, 16'h00a5);
        chk_rd(8'h01, 16'h01ff);
        chk_rd(8'h94, 16'h00a5);
        chk_rd(8'h9c, 16'h0000);
        tgs_ctrl_i.wr(8'h9a, 16'h0030);
        tgs_ctrl_i.wr(8'h99, 16'h000d);
        tgs_ctrl_i.pulse();
        repeat (8) @(posedge mclk);
        #1;
        `CHK("fixed gain", 9'h125, g)
        `CHK("fixed busy", 1'b0, seq_busy)
        for (int i = 0; i < 6; i++)
            tgs_ctrl_i.wr(8'(i + 2), {7'h00, tbl[i]});
        setup(8'h02, 8'h07, 8'h86, 8'h04, 8'h00, 16'h0000);
        run(9'd48, 30, 9'd1, 9'd79, 284);
        setup(8'h00, 8'h06, 8'h02, 8'h00, 8'h08, 16'h0010);
        run(9'd16, 128, 9'd8, 9'd64, 128);
        setup(8'h00, 8'h01, 8'h02, 8'h00, 8'h00, 16'h0010);
        run(9'd16, 16, 9'd8, 9'd24, 16);
        setup(8'h00, 8'h00, 8'h82, 8'h00, 8'h00, 16'h0010);
        run(9'd16, 2, 9'd1, 9'd23, 2);
        setup(8'h00, 8'h00, 8'h82, 8'h00, 8'h02, 16'h0010);
        run(9'd16, 4, 9'd1, 9'd23, 4);
        setup(8'h00, 8'h03, 8'ha4, 8'h01, 8'h01, 16'h0010);
        run(9'd288, 2, 9'd1, 9'd295, 68);
        setup(8'h00, 8'h00, 8'h82, 8'h00, 8'h01, 16'h0030);
        cnt = 0;
        last_g = g;
        repeat (200)
        begin
            @(posedge mclk);
            #1;
            if (g !== last_g && g === 9'd16)
                cnt++;
            last_g = g;
        end
        `CHK("restarts", 1'b1, cnt >= 3)
        tgs_ctrl_i.wr(8'h99, 16'h0010);
        repeat (100) @(posedge mclk);
        #1;
        `CHK("repeat stopped", 1'b0, seq_busy)
        `CHK("rest gain", 9'd16, g)
        give_verdict();
    end
endmodule : test_time_gain_sequencer

`default_nettype wire
